/* File: bench/file_regs_model.sv */
`default_nettype none

module file_regs_model
    import core_exec_pkg::*;
(
    // Clock
    input wire logic clk_in,
    // Read side, combinational
    input wire logic [FILE_ADDR_WIDTH-1:0] raddr_in,
    output logic [DATA_WIDTH-1:0] rdata_out,
    // Write side
    input wire file_write_type write_in
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [DATA_WIDTH-1:0] mem [32];

    // Known filler so unused reads never look like a real operand
    initial
    begin
        foreach (mem[i]) mem[i] = 8'hA5;
    end

    assign rdata_out = mem[raddr_in];

    always @(posedge clk_in)
    begin
        if (write_in.we)
            mem[write_in.addr] <= write_in.data;
    end
endmodule // file_regs_model

`default_nettype wire

/* File: bench/test_core_incdec_skip_branch_op_or.sv */
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin n_errors++; \
    $display("[FAIL] t=%0t got %h exp %h", $time, (a), (b)); end end

module test_core_incdec_skip_branch_op_or;
    timeunit 1ns;
    timeprecision 1ns;
    import core_exec_pkg::*;

    logic clk_in = 1'b0;
    logic resetn_in = 1'b0;
    logic [11:0] instr_in = 12'h000;
    logic instr_valid_in = 1'b0;
    logic [7:0] status_in = 8'h00;
    logic [7:0] file_rdata;
    file_write_type file_write;
    logic [7:0] acc;
    logic zero;
    pc_load_type pc_load;
    logic skip;
    logic discard;
    int n_errors = 0;
    int checks_done = 0;
    int cycles = 0;
    logic [7:0] acc_m;
    logic zero_m;

    always #25 clk_in = ~clk_in;

    core_incdec_skip_branch_op_or DUT (.clk_in(clk_in), .resetn_in(resetn_in), .instr_in(instr_in),
        .instr_valid_in(instr_valid_in), .file_rdata_in(file_rdata), .status_in(status_in),
        .file_write_out(file_write), .acc_out(acc), .zero_out(zero), .pc_load_out(pc_load),
        .skip_out(skip), .discard_out(discard));

    file_regs_model fm (.clk_in(clk_in), .raddr_in(instr_in[4:0]), .rdata_out(file_rdata),
        .write_in(file_write));

    task end_sim;
        if (n_errors == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // One slot, taken at the second edge; returns once its results have landed
    task slot(input logic [11:0] i);
        @(posedge clk_in);
        instr_in <= i;
        instr_valid_in <= 1'b1;
        @(posedge clk_in);
        instr_valid_in <= 1'b0;
        #1;
    endtask

    task expect_out(input logic we, input logic [7:0] data, input logic sk, input logic ds);
        `CHK(acc, acc_m)
        `CHK(zero, zero_m)
        `CHK(file_write.we, we)
        if (we) `CHK({file_write.addr, file_write.data}, {instr_in[4:0], data})
        `CHK(skip, sk)
        `CHK(discard, ds)
    endtask

    task t_incdec;
        logic [7:0] vals [4] = '{8'h01, 8'hFF, 8'h00, 8'h7F};
        logic [7:0] v;
        logic [7:0] r;
        logic [4:0] f;
        for (int k = 0; k < 16; k++)
        begin
            v = vals[k % 4];
            f = 5'(k + 3);
            r = k[3] ? v + 8'h01 : v - 8'h01;
            fm.mem[f] = v;
            slot((k[3] ? 12'h280 : 12'h0C0) | {6'h00, k[2], f});
            zero_m = (r == 8'h00);
            if (!k[2]) acc_m = r;
            expect_out(k[2], r, 1'b0, 1'b0);
        end
    endtask

    task t_skip;
        logic [7:0] v;
        logic [7:0] r;
        logic [4:0] f;
        logic d;
        logic hit;
        for (int k = 0; k < 4; k++)
        begin
            v = k[1] ? (k[0] ? 8'hFF : 8'h10) : (k[0] ? 8'h01 : 8'h05);
            r = k[1] ? v + 8'h01 : v - 8'h01;
            f = 5'(20 + k);
            d = k[1] ^ k[0];
            hit = (r == 8'h00);
            fm.mem[f] = v;
            slot((k[1] ? 12'h3C0 : 12'h2C0) | {6'h00, d, f});
            if (!d) acc_m = r;
            expect_out(d, r, hit, hit);
            if (hit)
            begin
                slot(12'h29F);
                expect_out(1'b0, 8'h00, 1'b0, 1'b0);
            end
        end
    endtask

    task t_branch;
        logic [8:0] k9;
        for (int p = 0; p < 4; p++)
        begin
            k9 = p[0] ? 9'h1FF : 9'h0A5;
            @(posedge clk_in);
            status_in <= {1'b1, p[1:0], 5'h1F};
            slot(12'hA00 | {3'h0, k9});
            `CHK(pc_load, {1'b1, p[1:0], k9})
            expect_out(1'b0, 8'h00, 1'b0, 1'b1);
            slot(12'hDFF);
            expect_out(1'b0, 8'h00, 1'b0, 1'b0);
            `CHK(pc_load.load, 1'b0)
        end
    endtask

    task t_or;
        logic [7:0] lits [4] = '{8'h00, 8'hF0, 8'h0F, 8'h00};
        fm.mem[2] = 8'h01;
        slot(12'h0C2);
        acc_m = 8'h00;
        zero_m = 1'b1;
        expect_out(1'b0, 8'h00, 1'b0, 1'b0);
        foreach (lits[i])
        begin
            slot(12'hD00 | {4'h0, lits[i]});
            acc_m = acc_m | lits[i];
            zero_m = (acc_m == 8'h00);
            expect_out(1'b0, 8'h00, 1'b0, 1'b0);
        end
    endtask

    // Reset in mid-run while a discard is armed; the next slot must execute
    task t_reset;
        slot(12'hA23);
        `CHK(discard, 1'b1)
        @(posedge clk_in);
        resetn_in <= 1'b0;
        @(posedge clk_in);
        #1;
        `CHK({acc, zero, pc_load, discard, skip}, {ACC_RESET, ZERO_RESET, 1'b0, PC_RESET, 2'b00})
        @(posedge clk_in);
        resetn_in <= 1'b1;
        acc_m = ACC_RESET;
        zero_m = ZERO_RESET;
        slot(12'hD0F);
        acc_m = 8'h0F;
        zero_m = 1'b0;
        expect_out(1'b0, 8'h00, 1'b0, 1'b0);
    endtask

    // Hang guard: the whole sequence needs under a hundred cycles
    always @(posedge clk_in)
    begin
        cycles++;
        if (cycles == 1000)
        begin
            n_errors++;
            end_sim();
        end
    end

    initial
    begin
        repeat (2) @(posedge clk_in);
        `CHK({acc, zero, pc_load.value}, {ACC_RESET, ZERO_RESET, PC_RESET})
        resetn_in <= 1'b1;
        acc_m = ACC_RESET;
        zero_m = ZERO_RESET;
        t_incdec();
        t_skip();
        t_branch();
        t_or();
        t_reset();
        end_sim();
    end
endmodule // test_core_incdec_skip_branch_op_or

`default_nettype wire

/* File: hdl/core_incdec_skip_branch_op_or.sv */
// Contract
// [RULE1] decrement_file_op: file minus one to accumulator (d=0) or file (d=1); zero updated
// [RULE2] increment_file_op: file plus one to accumulator (d=0) or file (d=1); zero updated
// [RULE3] decrement_skip_zero_op: decrement to destination, flags kept, skip on zero result
// [RULE4] increment_skip_zero_op: increment to destination, flags kept, skip on zero result
// [RULE5] Skip discards the already fetched next instruction as no_operation; two cycles
// [RULE6] branch_op loads immediate into pc 8:0 and status 6:5 into pc 10:9
// [RULE7] branch_op takes two cycles and leaves all flags unchanged
// [RULE8] or_literal_op ORs accumulator with literal into accumulator; zero updated
// [RULE9] Zero flag set when 8-bit result is zero, cleared otherwise
`default_nettype none

module core_incdec_skip_branch_op_or
    import core_exec_pkg::*;
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic resetn_in,
    // Instruction slot
    input wire logic [INSTR_WIDTH-1:0] instr_in,
    input wire logic instr_valid_in,
    // File register read data and status page bits
    input wire logic [DATA_WIDTH-1:0] file_rdata_in,
    input wire logic [DATA_WIDTH-1:0] status_in,
    // File register write port
    output var file_write_type file_write_out,
    // Core state
    output logic [DATA_WIDTH-1:0] acc_out,
    output logic zero_out,
    // Program flow
    output var pc_load_type pc_load_out,
    output logic skip_out,
    output logic discard_out
);

    typedef enum logic {st_run, st_flush} slot_state_type;

    slot_state_type state;
    logic exec;
    logic is_dec;
    logic is_inc;
    logic is_dsz;
    logic is_isz;
    logic is_branch;
    logic is_or;
    logic dest_file;
    logic [DATA_WIDTH-1:0] dec_value;
    logic [DATA_WIDTH-1:0] inc_value;
    logic [DATA_WIDTH-1:0] or_value;
    logic [DATA_WIDTH-1:0] alu_result;
    logic file_op;
    logic zero_update;
    logic skip_hit;

    // Decode; a slot in flush state is never executed
    assign exec = instr_valid_in && (state == st_run);
    assign is_dec = instr_in[11:6] == DECREMENT_FILE_OPCODE;
    assign is_inc = instr_in[11:6] == INCREMENT_FILE_OPCODE;
    assign is_dsz = instr_in[11:6] == DECREMENT_SKIP_OPCODE;
    assign is_isz = instr_in[11:6] == INCREMENT_SKIP_OPCODE;
    assign is_branch = instr_in[11:9] == BRANCH_OPCODE;
    assign is_or = instr_in[11:8] == OR_LITERAL_OPCODE;
    assign dest_file = instr_in[DEST_BIT];

    assign dec_value = file_rdata_in - 8'h01;
    assign inc_value = file_rdata_in + 8'h01;
    assign or_value = acc_out | instr_in[7:0];
    assign file_op = is_dec || is_inc || is_dsz || is_isz;
    assign zero_update = exec && (is_dec || is_inc || is_or);

    always_comb
    begin
        if (is_dec || is_dsz)
        begin
            alu_result = dec_value;
        end
        else if (is_inc || is_isz)
        begin
            alu_result = inc_value;
        end
        else
        begin
            alu_result = or_value;
        end
    end

    assign skip_hit = exec && (is_dsz || is_isz) && (alu_result == 8'h00); // [RULE3] [RULE4]

    // Accumulator
    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            acc_out <= ACC_RESET;
        end
        else if (exec && file_op && !dest_file)
        begin
            acc_out <= alu_result; // [RULE1] [RULE2] [RULE3] [RULE4]
        end
        else if (exec && is_or)
        begin
            acc_out <= or_value; // [RULE8]
        end
    end

    // File write-back, one cycle after the slot
    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            file_write_out <= '0;
        end
        else
        begin
            file_write_out.we <= exec && file_op && dest_file; // [RULE1] [RULE2]
            file_write_out.addr <= instr_in[FILE_ADDR_WIDTH-1:0];
            file_write_out.data <= alu_result;
        end
    end

    // Zero flag; skip forms and branch never touch it
    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            zero_out <= ZERO_RESET;
        end
        else if (zero_update)
        begin
            zero_out <= (alu_result == 8'h00); // [RULE9]
        end
    end

    // Branch target
    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            pc_load_out.load <= 1'b0;
            pc_load_out.value <= PC_RESET;
        end
        else
        begin
            pc_load_out.load <= exec && is_branch;
            if (exec && is_branch)
            begin
                pc_load_out.value <= {status_in[PAGE_MSB:PAGE_LSB],
                    instr_in[BRANCH_IMM_WIDTH-1:0]}; // [RULE6]
            end
        end
    end

    // Slot control: the fetched follower of a skip or branch becomes no_operation
    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            state <= st_run;
            discard_out <= 1'b0;
            skip_out <= 1'b0;
        end
        else
        begin
            skip_out <= skip_hit;
            unique case (state)
                st_run:
                begin
                    if (skip_hit || (exec && is_branch))
                    begin
                        state <= st_flush; // [RULE5] [RULE7]
                        discard_out <= 1'b1;
                    end
                end
                st_flush:
                begin
                    if (instr_valid_in)
                    begin
                        state <= st_run; // [RULE5]
                        discard_out <= 1'b0;
                    end
                end
            endcase
        end
    end

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!resetn_in);

    sequence s_skip_taken;
        skip_hit;
    endsequence

    sequence s_slot_dropped;
        discard_out && instr_valid_in;
    endsequence

    a_dec_result: assert property ( // [RULE1]
        exec && is_dec |=> (file_write_out.we ? file_write_out.data : acc_out)
            == ($past(file_rdata_in) - 8'h01) && file_write_out.we == $past(dest_file))
        else $error("decrement result or destination wrong");

    a_inc_result: assert property ( // [RULE2]
        exec && is_inc |=> (file_write_out.we ? file_write_out.data : acc_out)
            == ($past(file_rdata_in) + 8'h01) && file_write_out.we == $past(dest_file))
        else $error("increment result or destination wrong");

    a_dsz_skip: assert property ( // [RULE3]
        exec && is_dsz |=> skip_out == ($past(file_rdata_in) == 8'h01)
            && zero_out == $past(zero_out))
        else $error("decrement skip wrong or flag changed");

    a_isz_skip: assert property ( // [RULE4]
        exec && is_isz |=> skip_out == ($past(file_rdata_in) == 8'hFF)
            && zero_out == $past(zero_out))
        else $error("increment skip wrong or flag changed");

    a_skip_flush: assert property ( // [RULE5]
        s_skip_taken |=> discard_out && skip_out)
        else $error("skip not taken or discard not armed");

    // The wait for the follower is open-ended, so the drop is checked from its own edge
    a_slot_dropped: assert property ( // [RULE5]
        s_slot_dropped |=> !discard_out && !file_write_out.we && !pc_load_out.load
            && !skip_out && acc_out == $past(acc_out) && zero_out == $past(zero_out))
        else $error("skipped slot was executed");

    a_branch_target: assert property ( // [RULE6]
        exec && is_branch |=> pc_load_out.load
            && pc_load_out.value == {$past(status_in[6:5]), $past(instr_in[8:0])})
        else $error("branch target wrong");

    a_branch_cycles: assert property ( // [RULE7]
        exec && is_branch |=> discard_out && zero_out == $past(zero_out)
            && acc_out == $past(acc_out))
        else $error("branch not two cycles or flags changed");

    a_or_result: assert property ( // [RULE8]
        exec && is_or |=> acc_out == ($past(acc_out) | $past(instr_in[7:0])))
        else $error("or literal result wrong");

    a_zero_flag: assert property ( // [RULE9]
        zero_update |=> zero_out == ($past(alu_result) == 8'h00))
        else $error("zero flag does not match result");

endmodule // core_incdec_skip_branch_op_or

`default_nettype wire

/* File: include/core_exec_pkg.sv */
`default_nettype none

package core_exec_pkg;

    // Instruction word layout
    localparam int INSTR_WIDTH = 12;
    localparam int DATA_WIDTH = 8;
    localparam int FILE_ADDR_WIDTH = 5;
    localparam int PC_WIDTH = 11;
    localparam int BRANCH_IMM_WIDTH = 9;
    localparam int DEST_BIT = 5;
    localparam int PAGE_LSB = 5;
    localparam int PAGE_MSB = 6;

    // Opcode patterns, compared against the bits above the operand
    localparam logic [5:0] DECREMENT_FILE_OPCODE = 6'h03;
    localparam logic [5:0] INCREMENT_FILE_OPCODE = 6'h0A;
    localparam logic [5:0] DECREMENT_SKIP_OPCODE = 6'h0B;
    localparam logic [5:0] INCREMENT_SKIP_OPCODE = 6'h0F;
    localparam logic [2:0] BRANCH_OPCODE = 3'h5;
    localparam logic [3:0] OR_LITERAL_OPCODE = 4'hD;

    // Reset values
    localparam logic [7:0] ACC_RESET = 8'h00;
    localparam logic ZERO_RESET = 1'b0;
    localparam logic [10:0] PC_RESET = 11'h000;

    typedef struct packed {
        logic we;
        logic [FILE_ADDR_WIDTH-1:0] addr;
        logic [DATA_WIDTH-1:0] data;
    } file_write_type;

    typedef struct packed {
        logic load;
        logic [PC_WIDTH-1:0] value;
    } pc_load_type;

endpackage

`default_nettype wire
